// ==== verilog/ssd_sensor_fsm.v ====
`timescale 1ns/1ps
`include "ssd_consts.vh"

module ssd_sensor_fsm #(
  parameter MS_CYC    = `SSD_MS_CYC,
  parameter ANALYSIS  = `SSD_ANALYSIS_MS,
  parameter DIAG_MS   = `SSD_DIAG_S * 1000,
  parameter WARN_MS   = `SSD_WARN_S * 1000,
  parameter TEST_MS   = `SSD_TEST_MS,
  parameter PULSE_CYC = `SSD_PULSE_CYC
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Indicators
  output reg         ledGreen,
  output reg         ledYellow,
  output reg         ledRed,
  // Outputs
  output reg         diagOut,
  output reg         safety_out_a,
  output reg         safety_out_b,
  // Interrupt
  output wire        irq
);
  // States
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ACT  = 3'd1;
  localparam [2:0] ST_WARN = 3'd2;
  localparam [2:0] ST_FAIL = 3'd3;

  reg  [31:0] ctrl_q;          // Control register
  reg  [3:0]  irqSt_q;         // Sticky events
  reg  [3:0]  irqMsk_q;        // Interrupt mask
  reg  [2:0]  state_q;         // Sequencer state
  reg  [2:0]  state_d;         // Next state
  reg  [17:0] msCnt_q;         // Millisecond prescaler
  reg  [16:0] faultMs_q;       // Time since fault
  reg  [7:0]  blinkMs_q;       // 250 ms half-period
  reg         blink_q;         // 2 Hz square wave
  reg  [6:0]  testMs_q;        // Self-test interval
  reg  [15:0] pulseCnt_q;      // Off-pulse length
  reg         actPrev_q;       // Actuator level delay
  reg         faultPrev_q;     // Fault level delay
  wire        msTick;          // 1 ms enable
  wire        halfTick;        // 250 ms enable
  wire        actuated;        // Actuator present
  wire        limitRng;        // Limit range
  wire [2:0]  faultCode;       // 0 none, else 1..7
  wire        faultOn;         // Fault present
  wire        analysisDone;    // Steady red over
  wire        diagDone;        // Diagnostic delay over
  wire        warnDone;        // Warning over
  wire        flashOn;         // Red flash lamp
  wire        apbWr;           // Write strobe
  wire        apbRd;           // Read strobe
  wire        addrOk;          // Mapped address
  wire [31:0] pulseLen;        // Off-pulse load, full width

  // Ms count compare, shared
  function reached;
    input [16:0] cnt;
    input [31:0] lim;
    begin
      reached = ({15'h0000, cnt} >= lim);
    end
  endfunction

  assign actuated  = ctrl_q[`SSD_CTRL_ACT];
  assign limitRng  = ctrl_q[`SSD_CTRL_LIMIT];
  assign faultCode = ctrl_q[`SSD_CTRL_FLT_HI:`SSD_CTRL_FLT_LO];
  assign faultOn   = (faultCode != 3'd0);

  // APB: zero-wait, slverr on unmapped
  assign pready  = 1'b1;
  assign apbWr   = psel & penable & pwrite;
  assign apbRd   = psel & penable & ~pwrite;
  assign addrOk  = (paddr == `SSD_OFF_CTRL) ||
                   (paddr == `SSD_OFF_STATUS) ||
                   (paddr == `SSD_OFF_IRQST) ||
                   (paddr == `SSD_OFF_IRQMSK);
  assign pslverr = psel & penable & ~addrOk;
  assign irq     = |(irqSt_q & irqMsk_q);

  // Register writes
  always @(posedge clk) begin
    if (rst) begin
      ctrl_q   <= `SSD_CTRL_RST;
      irqMsk_q <= `SSD_IRQMSK_RST;
    end else if (apbWr) begin
      if (paddr == `SSD_OFF_CTRL) begin
        ctrl_q <= {26'h000_0000, pwdata[5:0]};
      end
      if (paddr == `SSD_OFF_IRQMSK) begin
        irqMsk_q <= pwdata[3:0];
      end
    end
  end

  // Read data mux, registered
  // Loaded in setup so data stands settled through access
  always @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `SSD_OFF_CTRL:   prdata <= ctrl_q;
        `SSD_OFF_STATUS: prdata <= {21'h00_0000, diagOut, safety_out_b,
                                    safety_out_a, ledRed, ledYellow,
                                    ledGreen, flashOn, 1'b0, state_q};
        `SSD_OFF_IRQST:  prdata <= {28'h000_0000, irqSt_q};
        `SSD_OFF_IRQMSK: prdata <= {28'h000_0000, irqMsk_q};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Sticky events: set beats read-clear
  // A read clears only the bits it reported, so an event that lands
  // between setup and access is kept for the next read
  always @(posedge clk) begin
    if (rst) begin
      irqSt_q     <= 4'h0;
      actPrev_q   <= 1'b0;
      faultPrev_q <= 1'b0;
    end else begin
      actPrev_q   <= actuated;
      faultPrev_q <= faultOn;
      irqSt_q     <= (apbRd && paddr == `SSD_OFF_IRQST) ?
                     (irqSt_q & ~prdata[3:0]) : irqSt_q;
      // Fault start is an edge, so a read does not re-arm it
      if (faultOn && !faultPrev_q) begin
        irqSt_q[`SSD_IRQ_FAULT] <= 1'b1;
      end
      if (state_d == ST_FAIL && state_q != ST_FAIL) begin
        irqSt_q[`SSD_IRQ_FAIL] <= 1'b1;
      end
      if (actuated != actPrev_q) begin
        irqSt_q[`SSD_IRQ_ACTCHG] <= 1'b1;
      end
    end
  end

  // Millisecond and blink dividers
  // Free-running, so blink phase is independent of state entry
  assign msTick   = (msCnt_q == MS_CYC - 1);
  assign halfTick = msTick && (blinkMs_q == 8'd249);
  always @(posedge clk) begin
    if (rst) begin
      msCnt_q   <= 18'h0_0000;
      blinkMs_q <= 8'h00;
      blink_q   <= 1'b0;
    end else begin
      msCnt_q <= msTick ? 18'h0_0000 : msCnt_q + 18'h0_0001;
      if (msTick) begin
        blinkMs_q <= halfTick ? 8'h00 : blinkMs_q + 8'h01;
      end
      if (halfTick) begin
        blink_q <= ~blink_q;
      end
    end
  end

  // Fault age in ms, saturating
  // Held at zero without a fault, so each fault restarts timing
  assign analysisDone = reached(faultMs_q, ANALYSIS);
  assign diagDone     = reached(faultMs_q, DIAG_MS);
  assign warnDone     = reached(faultMs_q, WARN_MS);
  always @(posedge clk) begin
    if (rst || !faultOn) begin
      faultMs_q <= 17'h0_0000;
    end else if (msTick && !warnDone) begin
      faultMs_q <= faultMs_q + 17'h0_0001;
    end
  end

  // Sequencer next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (actuated) state_d = faultOn ? ST_WARN : ST_ACT;
      ST_ACT: begin
        if (!actuated) state_d = ST_IDLE;
        else if (faultOn) state_d = ST_WARN;
      end
      ST_WARN: begin
        // Guard opened: drop at once, warning or not
        if (!actuated) state_d = ST_IDLE;
        else if (!faultOn) state_d = ST_ACT;
        else if (warnDone) state_d = ST_FAIL;
      end
      // Failure holds until the fault code clears
      ST_FAIL: if (!faultOn) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // State register
  always @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Full-width copy of the pulse length, cut on purpose below
  assign pulseLen = PULSE_CYC;

  // Self-test pulse scheduler
  always @(posedge clk) begin
    if (rst || !ctrl_q[`SSD_CTRL_TEST]) begin
      testMs_q   <= 7'h00;
      pulseCnt_q <= 16'h0000;
    end else begin
      if (msTick) begin
        testMs_q <= (testMs_q == TEST_MS - 1) ? 7'h00 : testMs_q + 7'h01;
      end
      if (msTick && testMs_q == TEST_MS - 1) begin
        pulseCnt_q <= pulseLen[15:0];
      end else if (pulseCnt_q != 16'h0000) begin
        pulseCnt_q <= pulseCnt_q - 16'h0001;
      end
    end
  end

  // Red flash groups keyed by fault code
  ssd_flash_gen #(
    .CNT_W (3)
  ) uFlash (
    .clk     (clk),
    .rst     (rst),
    .tick    (halfTick),
    .enable  (faultOn && analysisDone),
    .code    (faultCode),
    .flashOn (flashOn)
  );

  // Output registers
  // Driven from the next state: pins follow inputs by one edge
  always @(posedge clk) begin
    if (rst) begin
      ledGreen     <= 1'b1;
      ledYellow    <= 1'b0;
      ledRed       <= 1'b0;
      diagOut      <= 1'b0;
      safety_out_a <= 1'b0;
      safety_out_b <= 1'b0;
    end else begin
      case (state_d)
        ST_ACT: begin
          ledGreen  <= 1'b0;
          ledYellow <= limitRng ? blink_q : 1'b1;
          ledRed    <= 1'b0;
          diagOut   <= limitRng ? blink_q : 1'b1;
          safety_out_a <= (pulseCnt_q == 16'h0000);
          safety_out_b <= (pulseCnt_q == 16'h0000);
        end
        ST_WARN: begin
          ledGreen  <= 1'b0;
          ledYellow <= 1'b0;
          ledRed    <= analysisDone ? flashOn : 1'b1;
          diagOut   <= !diagDone;
          safety_out_a <= (pulseCnt_q == 16'h0000);
          safety_out_b <= (pulseCnt_q == 16'h0000);
        end
        ST_FAIL: begin
          ledGreen     <= 1'b0;
          ledYellow    <= 1'b0;
          ledRed       <= 1'b1;
          diagOut      <= 1'b0;
          safety_out_a <= 1'b0;
          safety_out_b <= 1'b0;
        end
        default: begin
          ledGreen     <= 1'b1;
          ledYellow    <= 1'b0;
          ledRed       <= 1'b0;
          diagOut      <= 1'b0;
          safety_out_a <= 1'b0;
          safety_out_b <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ==== include/ssd_consts.vh ====
`ifndef SSD_CONSTS_VH
`define SSD_CONSTS_VH
// APB register byte offsets
`define SSD_OFF_CTRL    12'h000
`define SSD_OFF_STATUS  12'h004
`define SSD_OFF_IRQST   12'h008
`define SSD_OFF_IRQMSK  12'h00C
// Control register fields
`define SSD_CTRL_ACT    0
`define SSD_CTRL_LIMIT  1
`define SSD_CTRL_FLT_LO 2
`define SSD_CTRL_FLT_HI 4
`define SSD_CTRL_TEST   5
// Interrupt status bits
`define SSD_IRQ_FAULT   0
`define SSD_IRQ_FAIL    1
`define SSD_IRQ_ACTCHG  2
// Reset values
`define SSD_CTRL_RST    32'h0000_0020
`define SSD_IRQMSK_RST  4'h0
// Timing: 250 MHz clock, 4 ns
`define SSD_CLK_HZ      250000000
`define SSD_MS_CYC      (`SSD_CLK_HZ / 1000)
`define SSD_ANALYSIS_MS 1000
`define SSD_DIAG_S      10
`define SSD_WARN_S      60
`define SSD_BLINK_HZ    2
`define SSD_PULSE_US    250
`define SSD_PULSE_CYC   ((`SSD_CLK_HZ / 1000000) * `SSD_PULSE_US)
`define SSD_TEST_MS     100
`endif

// ==== verilog/ssd_flash_gen.v ====
`timescale 1ns/1ps
// Red flash group generator driven by a tick enable
module ssd_flash_gen #(
  parameter CNT_W = 3
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst,
  // Tick and code
  input  wire             tick,
  input  wire             enable,
  input  wire [CNT_W-1:0] code,
  // Lamp
  output reg              flashOn
);
  localparam [3:0] PAUSE = 4'd6;  // Dark ticks between groups
  reg [CNT_W-1:0] flashCnt_q;    // Flashes done in group
  reg [3:0]       pauseCnt_q;    // Dark pause countdown
  reg             phase_q;       // Half-period phase

  // Flash sequence: on/off per tick, then long pause
  always @(posedge clk) begin
    if (rst || !enable) begin
      flashCnt_q <= {CNT_W{1'b0}};
      pauseCnt_q <= PAUSE;
      phase_q    <= 1'b0;
      flashOn    <= 1'b0;
    end else if (tick) begin
      if (pauseCnt_q != 4'd0) begin
        // Long dark gap
        pauseCnt_q <= pauseCnt_q - 4'd1;
        flashOn    <= 1'b0;
      end else if (!phase_q) begin
        flashOn <= 1'b1;
        phase_q <= 1'b1;
      end else begin
        flashOn <= 1'b0;
        phase_q <= 1'b0;
        if (flashCnt_q + 1'b1 >= code) begin
          flashCnt_q <= {CNT_W{1'b0}};
          pauseCnt_q <= PAUSE;
        end else begin
          flashCnt_q <= flashCnt_q + 1'b1;
        end
      end
    end
  end
endmodule

// ==== tb/ssd_sensor_fsm_assertions.sv ====
`timescale 1ns/1ps
// Port checks on the sensor sequencer
module ssd_sensor_fsm_chk (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  // Lamps and outputs
  input wire        ledGreen,
  input wire        ledYellow,
  input wire        ledRed,
  input wire        diagOut,
  input wire        safety_out_a,
  input wire        safety_out_b,
  input wire        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire acc = psel && penable; // Access phase
  a_ready_always: assert property (acc |-> pready)
    else $error("pready low in access");
  a_unmapped_err: assert property (acc &&
    (paddr > 12'h00C || paddr[1:0] != 2'b00) |->
    pslverr && (pwrite || prdata == 32'h0000_0000))
    else $error("unmapped not refused");
  a_mapped_ok: assert property (acc && paddr[1:0] == 2'b00 &&
    paddr <= 12'h00C |-> !pslverr) else $error("mapped access refused");
  a_read_stands: assert property (acc && !pwrite |=> $stable(prdata))
    else $error("read data moved");
  a_idle_green: assert property (ledGreen |-> !ledYellow && !ledRed
    && !safety_out_a && !diagOut) else $error("idle not green only");
  a_chan_agree: assert property (safety_out_a == safety_out_b)
    else $error("channels differ");
  a_enter_drive: assert property ($rose(ledYellow) && $past(ledGreen)
    |-> ##[0:2] safety_out_a) else $error("outputs not driven");
  a_irq_clear: assert property (acc && !pwrite && paddr == 12'h008
    |=> !irq) else $error("irq not cleared by read");
  cover property ($rose(ledRed));
  cover property (acc && pslverr);
  cover property ($fell(safety_out_a) && ledYellow);
endmodule

// ==== tb/ssd_safety_monitor.sv ====
`timescale 1ns/1ps
// Monitoring module input, measures off-pulses
module ssd_safety_monitor #(
  parameter PULSE_CYC = 5
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Channels from the sensor
  input  wire        chanA,
  input  wire        chanB,
  // Width of last tolerated off-pulse
  output reg  [15:0] lastPulse
);
  reg [31:0] lowCnt; // Cycles the pair is off
  reg        wasOn;  // Pair on last cycle
  // Pair judged as one; no cross check here
  always @(posedge clk) begin
    if (rst) begin
      lowCnt    <= 0;
      wasOn     <= 1'b0;
      lastPulse <= 16'h0000;
    end else begin
      wasOn <= chanA & chanB;
      if (chanA & chanB) begin
        // Short off-time is a test, not a stop
        if (!wasOn && lowCnt <= 6 * PULSE_CYC)
          lastPulse <= lowCnt[15:0];
        lowCnt <= 0;
      end else
        lowCnt <= lowCnt + 1;
    end
  end
endmodule

// ==== tb/ssd_sensor_fsm_bench.sv ====
`timescale 1ns/1ps
`include "ssd_consts.vh"
// Self-checking bench, 10 cycles per ms
module ssd_sensor_fsm_bench;
  localparam PULSE = 5;    // Off-pulse cycles
  localparam TICK  = 2500; // 250 ms
  reg clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, watch = 0;
  reg  [11:0] paddr = 0;
  reg  [31:0] pwdata = 0, d;
  reg         e, redP, diagP, yelP;
  wire [31:0] prdata;
  wire [15:0] lastPulse;
  wire pready, pslverr, ledGreen, ledYellow, ledRed, diagOut, irq;
  wire sA, sB;
  int badCount = 0, samplesChecked = 0, cyc = 0, i;
  int redRise, diagRise, yelRise, aLow, offRun, maxOff;
  logic [31:0] rowCtrl [4] = '{1, 0, 1, 0};
  logic [31:0] rowStat [4] = '{32'h0000_0741, 32'h0000_0020,
                               32'h0000_0741, 32'h0000_0020};
  ssd_sensor_fsm #(.MS_CYC(10), .ANALYSIS(2), .DIAG_MS(10),
    .WARN_MS(5000), .TEST_MS(5), .PULSE_CYC(PULSE)) uut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ledGreen(ledGreen),
    .ledYellow(ledYellow), .ledRed(ledRed), .diagOut(diagOut),
    .safety_out_a(sA), .safety_out_b(sB), .irq(irq));
  ssd_safety_monitor #(.PULSE_CYC(PULSE)) mon (.clk(clk), .rst(rst),
    .chanA(sA), .chanB(sB), .lastPulse(lastPulse));
  always #2 clk = ~clk;
  // Edge and run counters over a watched window
  always @(posedge clk) begin
    redP <= ledRed;
    diagP <= diagOut;
    yelP <= ledYellow;
    if (!watch) begin
      {redRise, diagRise, yelRise, aLow, offRun, maxOff} <= 0;
    end else begin
      redRise <= redRise + (ledRed && !redP);
      diagRise <= diagRise + (diagOut && !diagP);
      yelRise <= yelRise + (ledYellow && !yelP);
      aLow <= aLow + !sA;
      offRun <= ledRed ? 0 : offRun + 1;
      if (offRun > maxOff) maxOff <= offRun;
    end
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      badCount++;
      giveVerdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic apb(input [11:0] a, input w, input [31:0] wd);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    d = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    #1;
  endtask
  task automatic check(input string nm, input logic [31:0] s, x);
    samplesChecked++;
    if (s !== x) begin
      badCount++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 4; i++) begin
      apb(`SSD_OFF_CTRL, 1, rowCtrl[i]);
      tick(3);
      apb(`SSD_OFF_STATUS, 0, 0);
      check("status", d, rowStat[i]);
      check("pins", {diagOut, sA, ledRed, ledYellow, ledGreen},
            {rowStat[i][10], rowStat[i][8:5]});
    end
    apb(`SSD_OFF_IRQST, 0, 0);
    apb(`SSD_OFF_IRQMSK, 1, 1);
    apb(`SSD_OFF_CTRL, 1, 32'h0000_0021);
    tick(200);
    check("pulse", lastPulse, PULSE);
    check("irq masked", irq, 0);
    apb(`SSD_OFF_IRQST, 0, 0);
    check("irqst", d, 32'h0000_0004);
    apb(`SSD_OFF_CTRL, 1, 32'h0000_0003);
    tick(10);
    watch = 1;
    tick(10000);
    watch = 0;
    check("diag rises", diagRise, 2);
    check("yellow rises", yelRise, 2);
    check("out low", aLow, 0);
    apb(`SSD_OFF_CTRL, 1, 32'h0000_000D);
    tick(1);
    check("irq", irq, 1);
    apb(`SSD_OFF_IRQST, 0, 0);
    check("fault event", d, 32'h0000_0001);
    check("irq cleared", irq, 0);
    tick(6);
    check("red", ledRed, 1);
    tick(80);
    check("diag held", diagOut, 1);
    tick(20);
    check("diag low", diagOut, 0);
    tick(4890);
    watch = 1;
    tick(30000);
    watch = 0;
    check("flashes", redRise, 3);
    check("gap", maxOff > 2 * TICK, 1);
    tick(14990);
    check("warn out", sA, 1);
    tick(20);
    check("fail out", {sA, ledRed}, 2'b01);
    apb(`SSD_OFF_STATUS, 0, 0);
    check("fail state", d[2:0], 3);
    @(posedge clk) rst <= 1'b1;
    tick(2);
    check("reset pins", {diagOut, sA, ledRed, ledYellow, ledGreen}, 1);
    @(posedge clk) rst <= 1'b0;
    apb(`SSD_OFF_CTRL, 0, 0);
    check("ctrl rst", d, `SSD_CTRL_RST);
    apb(`SSD_OFF_IRQMSK, 0, 0);
    check("mask rst", d, 0);
    apb(`SSD_OFF_CTRL, 1, 32'h0000_000D);
    tick(3);
    check("warn on", sA, 1);
    apb(`SSD_OFF_CTRL, 1, 32'h0000_000C);
    tick(2);
    check("leave off", {sA, ledGreen}, 2'b01);
    apb(12'h010, 0, 0);
    check("unmapped err", e, 1);
    check("unmapped data", d, 0);
    giveVerdict();
  end
endmodule
bind ssd_sensor_fsm ssd_sensor_fsm_chk chk (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .ledGreen(ledGreen), .ledYellow(ledYellow), .ledRed(ledRed),
  .diagOut(diagOut), .safety_out_a(safety_out_a),
  .safety_out_b(safety_out_b), .irq(irq));
